//--- shared/qdc_consts.vh
// Field positions, codes and reset values of the quad converter update block
`ifndef QDC_CONSTS_VH
`define QDC_CONSTS_VH

// Control byte field positions
`define QDC_CTRL_PD_BIT 0
`define QDC_CTRL_SEL_LO 1
`define QDC_CTRL_SEL_HI 2
`define QDC_CTRL_MODE_LO 4
`define QDC_CTRL_MODE_HI 5

// Update modes
`define QDC_MODE_TEMP 2'b00
`define QDC_MODE_ONE 2'b01
`define QDC_MODE_ALL 2'b10
`define QDC_MODE_BCAST 2'b11

// High byte field positions for sleep command bits
`define QDC_SLEEP_HI_BIT 7
`define QDC_SLEEP_LO_BIT 6

// Low byte code bits live in the top two positions
`define QDC_LOW_CODE_HI 7
`define QDC_LOW_CODE_LO 6

// Register word layout
`define QDC_WORD_W 12
`define QDC_CODE_W 10
`define QDC_PD_NORMAL 2'b00

// Reset values
`define QDC_WORD_RST 12'h000
`define QDC_BYTE_RST 8'h00

// Serial bit count of one byte plus acknowledge slot
`define QDC_ACK_SLOT 4'h8
`define QDC_BIT_LAST 4'h9

`endif

//--- src/qdc_update.v
// Control byte decode and channel register update of a quad converter
`timescale 1ns/1ps
`include "qdc_consts.vh"

module qdc_update #(
   parameter CH_N = 4
) (
   input wire clk_sys_in,
   input wire reset_in,
   input wire scl_in,
   input wire sda_in,
   input wire addr_match_in,
   input wire bcast_match_in,
   output wire sda_out,
   output wire sda_oe_out,
   output wire [7:0] control_out,
   output wire [CH_N*12-1:0] staging_out,
   output wire [CH_N*12-1:0] output_code_out,
   output wire update_out
);

   // State codes, one-hot
   localparam [5:0] ST_IDLE = 6'h01;
   localparam [5:0] ST_ADDR = 6'h02;
   localparam [5:0] ST_CTRL = 6'h04;
   localparam [5:0] ST_HI = 6'h08;
   localparam [5:0] ST_LO = 6'h10;
   localparam [5:0] ST_SKIP = 6'h20;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection

   reg [1:0] scl_sync_q;
   reg [1:0] sda_sync_q;
   reg scl_prev_q;
   reg sda_prev_q;

   // Two flops per pin, then a history flop
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_in};
         sda_sync_q <= {sda_sync_q[0], sda_in};
         scl_prev_q <= scl_sync_q[1];
         sda_prev_q <= sda_sync_q[1];
      end
   end

   // Synchronised pin levels
   wire scl_s = scl_sync_q[1];
   wire sda_s = sda_sync_q[1];
   // Edges of the synchronised clock
   wire scl_rise = scl_s & ~scl_prev_q;
   wire scl_fall = ~scl_s & scl_prev_q;
   // Data change while clock high marks frame boundaries
   wire start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   wire stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   ////////////////////////////////////////////////////////////////////////
   // Bit shifter and frame state

   reg [5:0] state_q;
   reg [5:0] state_d;
   reg [3:0] bit_cnt_q;
   reg [7:0] shift_q;
   reg acc_loc_q;
   reg acc_bc_q;
   reg ack_oe_q;
   reg ack_oe_d;
   reg sda_q;
   reg [7:0] ctrl_q;
   reg [7:0] hi_q;
   reg [7:0] lo_q;
   reg upd_q;

   // Byte done: acknowledge slot clock falls
   wire byte_end = scl_fall & (bit_cnt_q == `QDC_BIT_LAST);
   // Eighth data bit has been clocked in
   wire ack_start = scl_fall & (bit_cnt_q == `QDC_ACK_SLOT);
   // Inside a frame and no boundary this cycle
   wire frame_busy = (state_q != ST_IDLE) & ~start_det & ~stop_det;
   wire accepted = acc_loc_q | acc_bc_q;

   ////////////////////////////////////////////////////////////////////////
   // Control byte fields

   // Flag, update mode and channel pick of the held byte
   wire pd_flag = ctrl_q[`QDC_CTRL_PD_BIT];
   wire [1:0] mode = {ctrl_q[`QDC_CTRL_MODE_HI], ctrl_q[`QDC_CTRL_MODE_LO]};
   wire sel_hi = ctrl_q[`QDC_CTRL_SEL_HI];
   wire [1:0] ch_sel = {sel_hi, ctrl_q[`QDC_CTRL_SEL_LO]};

   // Next byte role after each acknowledge
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_ADDR: begin
            if (shift_q[0] | ~(addr_match_in | bcast_match_in))
               state_d = ST_SKIP;
            else
               state_d = ST_CTRL;
         end
         ST_CTRL: begin
            state_d = ST_HI;
         end
         ST_HI: begin
            state_d = ST_LO;
         end
         ST_LO: begin
            if (pd_flag)
               state_d = ST_SKIP;
            else
               state_d = ST_HI;
         end
         ST_IDLE: begin
            state_d = ST_IDLE;
         end
         ST_SKIP: begin
            state_d = ST_SKIP;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Frame state and bit position within the byte
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
      end else if (start_det) begin
         state_q <= ST_ADDR;
         bit_cnt_q <= 4'h0;
      end else if (stop_det) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
      end else if (state_q != ST_IDLE) begin
         if (scl_rise)
            bit_cnt_q <= bit_cnt_q + 4'h1;
         if (byte_end) begin
            bit_cnt_q <= 4'h0;
            state_q <= state_d;
         end
      end
   end

   // Data bits shift in on clock rise, acknowledge slot skipped
   always @(posedge clk_sys_in) begin
      if (reset_in)
         shift_q <= `QDC_BYTE_RST;
      else if (frame_busy & scl_rise & (bit_cnt_q != `QDC_ACK_SLOT))
         shift_q <= {shift_q[6:0], sda_s};
   end

   // Acceptance of this frame, decided by the address byte
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         acc_loc_q <= 1'b0;
         acc_bc_q <= 1'b0;
      end else if (start_det) begin
         acc_loc_q <= 1'b0;
         acc_bc_q <= 1'b0;
      end else if (frame_busy & ack_start & (state_q == ST_ADDR)) begin
         acc_loc_q <= addr_match_in & ~shift_q[0];
         acc_bc_q <= bcast_match_in & ~shift_q[0];
      end
   end

   // Holding registers take a finished byte by its role
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         ctrl_q <= `QDC_BYTE_RST;
         hi_q <= `QDC_BYTE_RST;
         lo_q <= `QDC_BYTE_RST;
      end else if (frame_busy & ack_start & accepted) begin
         if (state_q == ST_CTRL)
            ctrl_q <= shift_q;
         if (state_q == ST_HI)
            hi_q <= shift_q;
         if (state_q == ST_LO)
            lo_q <= shift_q;
      end
   end

   // Acknowledge decision for the byte now ending
   always @* begin
      ack_oe_d = ack_oe_q;
      if (start_det | stop_det | byte_end) begin
         ack_oe_d = 1'b0;
      end else if (ack_start) begin
         case (state_q)
            ST_ADDR: ack_oe_d = ~shift_q[0] &
                                (addr_match_in | bcast_match_in);
            ST_CTRL: ack_oe_d = accepted;
            ST_HI: ack_oe_d = accepted;
            ST_LO: ack_oe_d = accepted;
            default: ack_oe_d = 1'b0;
         endcase
      end
   end

   // Acknowledge drive during the ninth clock
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         ack_oe_q <= 1'b0;
         sda_q <= 1'b0;
      end else begin
         ack_oe_q <= ack_oe_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Update decision

   // Word update fires on the acknowledge fall after the low byte
   wire lo_done = byte_end & (state_q == ST_LO) & accepted;
   // Local modes need this device's own address
   wire loc_upd = lo_done & acc_loc_q & (mode != `QDC_MODE_BCAST);
   // Broadcast acts on either address match
   wire bc_upd = lo_done & (mode == `QDC_MODE_BCAST);

   // Registered marker of any register update
   always @(posedge clk_sys_in) begin
      if (reset_in)
         upd_q <= 1'b0;
      else
         upd_q <= loc_upd | bc_upd;
   end

   // Received data word, code layout
   wire [11:0] data_word = {`QDC_PD_NORMAL, hi_q,
      lo_q[`QDC_LOW_CODE_HI], lo_q[`QDC_LOW_CODE_LO]};
   // Sleep command rides in the top two high-byte bits
   wire [1:0] sleep_bits = {hi_q[`QDC_SLEEP_HI_BIT],
      hi_q[`QDC_SLEEP_LO_BIT]};

   ////////////////////////////////////////////////////////////////////////
   // Per-channel staging and output registers

   genvar gi;
   generate
      for (gi = 0; gi < CH_N; gi = gi + 1) begin : g_ch
         reg [11:0] tr_q;
         reg [11:0] tr_d;
         reg [11:0] dr_q;
         reg [11:0] dr_d;
         // Channel index compared at full width, no truncation
         wire sel = ({30'h0, ch_sel} == gi);
         // New staging content: data, or command above kept code
         wire [11:0] tr_new = pd_flag ?
            {sleep_bits, tr_q[`QDC_CODE_W-1:0]} : data_word;
         // Sleep command over the code the output already holds
         wire [11:0] dr_pd = {sleep_bits,
            dr_q[`QDC_CODE_W-1:0]};

         // Staging next value: only local words touch the selected one
         always @* begin
            tr_d = tr_q;
            if (loc_upd & sel)
               tr_d = tr_new;
         end

         // Output next value per update mode
         always @* begin
            dr_d = dr_q;
            if (loc_upd) begin
               case (mode)
                  `QDC_MODE_ONE: begin
                     if (sel)
                        dr_d = tr_new;
                  end
                  `QDC_MODE_ALL: begin
                     if (sel)
                        dr_d = tr_new;
                     else
                        dr_d = tr_q;
                  end
                  default: begin
                     dr_d = dr_q;
                  end
               endcase
            end else if (bc_upd) begin
               if (~sel_hi)
                  dr_d = tr_q;
               else if (pd_flag)
                  dr_d = dr_pd;
               else
                  dr_d = data_word;
            end
         end

         // Channel registers, cleared at reset
         always @(posedge clk_sys_in) begin
            if (reset_in) begin
               tr_q <= `QDC_WORD_RST;
               dr_q <= `QDC_WORD_RST;
            end else begin
               tr_q <= tr_d;
               dr_q <= dr_d;
            end
         end

         assign staging_out[gi*12 +: 12] = tr_q;
         assign output_code_out[gi*12 +: 12] = dr_q;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   // Open-drain data: low whenever the enable is high
   assign sda_out = sda_q;
   assign sda_oe_out = ack_oe_q;
   assign control_out = ctrl_q;
   assign update_out = upd_q;

endmodule

//--- tb/qdc_master.sv
// Serial bus master model driving the update block
`timescale 1ns/1ps
module qdc_master (
   input wire clk_sys_in,
   input wire sda_in,
   output logic scl_out,
   output logic sda_out
);
   // Bus idles released, clock stands still
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // Wait cycles then step off the edge
   task automatic st(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   // Data falls while clock high
   task automatic start();
      st(2);
      sda_out = 1'b0;
      st(2);
      scl_out = 1'b0;
   endtask
   // One clock of 160 ns, sampled mid-high
   task automatic bitx(input logic b, output logic r);
      st(1);
      sda_out = b;
      st(3);
      scl_out = 1'b1;
      st(2);
      r = sda_in;
      st(2);
      scl_out = 1'b0;
   endtask
   // Byte sent top bit first, then released for ack
   task automatic wb(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(v[i], r);
      bitx(1'b1, r);
      ack = !r;
   endtask
   // Data rises while clock high
   task automatic stop();
      st(1);
      sda_out = 1'b0;
      st(3);
      scl_out = 1'b1;
      st(2);
      sda_out = 1'b1;
      st(4);
   endtask
endmodule

//--- tb/qdc_update_props.sv
// Port assertions of the update block
`timescale 1ns/1ps
module qdc_update_props #(
   parameter CH_N = 4
) (
   input wire clk_sys_in,
   input wire reset_in,
   input wire scl_in,
   input wire sda_in,
   input wire addr_match_in,
   input wire bcast_match_in,
   input wire sda_out,
   input wire sda_oe_out,
   input wire [7:0] control_out,
   input wire [CH_N*12-1:0] staging_out,
   input wire [CH_N*12-1:0] output_code_out,
   input wire update_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   // Mode and selected words
   wire [1:0] mode = control_out[5:4];
   wire [11:0] so = output_code_out[control_out[2:1]*12 +: 12];
   wire [11:0] ss = staging_out[control_out[2:1]*12 +: 12];
   chk_pulse_once: assert property (update_out |=> !update_out)
      else $error("update pulse too long");
   chk_write_flag: assert property ($changed(staging_out) ||
      $changed(output_code_out) |-> update_out) else $error("no update");
   chk_temp_only: assert property ($changed(staging_out) &&
      mode == 2'b00 |-> $stable(output_code_out)) else $error("out moved");
   chk_one_both: assert property (update_out && mode == 2'b01 &&
      !control_out[0] |-> so == ss) else $error("selected differs");
   chk_all_load: assert property (update_out && mode == 2'b10 &&
      !control_out[0] |-> output_code_out == staging_out)
      else $error("load all differs");
   chk_bcast_stage: assert property (update_out && mode == 2'b11 &&
      !control_out[2] |-> output_code_out == staging_out)
      else $error("broadcast load differs");
   chk_bcast_data: assert property (update_out && mode == 2'b11 &&
      control_out[2] && !control_out[0] |->
      output_code_out == {CH_N{output_code_out[11:0]}})
      else $error("broadcast words differ");
   chk_ack_hold: assert property ($rose(sda_oe_out) |->
      sda_oe_out[*7]) else $error("ack too short");
   chk_reset_zero: assert property ($fell(reset_in) |->
      staging_out == 0 && output_code_out == 0 && control_out == 8'h00)
      else $error("not clear after reset");
endmodule
bind qdc_update qdc_update_props #(.CH_N(CH_N)) chk (.*);

//--- tb/qdc_update_bench.sv
// Self-checking bench of the update block
`timescale 1ns/1ps
module qdc_update_bench;
   logic clk_sys_in = 1'b0;
   logic reset_in = 1'b1;
   logic hit_addr = 1'b0;
   logic hit_bcast = 1'b0;
   logic [47:0] es = 48'h0;
   logic [47:0] eo = 48'h0;
   int num_errors = 0;
   int samples_checked = 0;
   int pulses = 0;
   wire scl, sdam, sda_o, sda_oe, upd;
   wire [7:0] ctl;
   wire [47:0] stg, outc;
   // Pull-up wire: low if either party pulls
   wire sda_w = sdam & (sda_oe ? sda_o : 1'b1);
   qdc_master m (.clk_sys_in(clk_sys_in), .sda_in(sda_w), .scl_out(scl),
      .sda_out(sdam));
   qdc_update uut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .scl_in(scl), .sda_in(sda_w), .addr_match_in(hit_addr),
      .bcast_match_in(hit_bcast), .sda_out(sda_o), .sda_oe_out(sda_oe),
      .control_out(ctl), .staging_out(stg), .output_code_out(outc),
      .update_out(upd));
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [47:0] e, g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask
   // Whole frame: address, control, one word
   task automatic put(input logic [7:0] c, h, l, input logic a, b);
      logic k;
      int p0;
      hit_addr = a;
      hit_bcast = b;
      p0 = pulses;
      m.start();
      m.wb(8'h98, k);
      m.wb(c, k);
      m.wb(h, k);
      m.wb(l, k);
      m.stop();
      check("ack", {47'h0, a | b}, {47'h0, k});
      check("update pulses", {47'h0, a | b}, 48'(pulses - p0));
      check("staging", es, stg);
      check("outputs", eo, outc);
   endtask
   task automatic t_temp();
      es[35:24] = 12'h155;
      put(8'h04, 8'h55, 8'h7F, 1'b1, 1'b0);
      check("control", 48'h04, {40'h0, ctl});
   endtask
   task automatic t_one();
      es[47:36] = 12'h3FF;
      eo[47:36] = 12'h3FF;
      put(8'h16, 8'hFF, 8'hC0, 1'b1, 1'b0);
   endtask
   task automatic t_all();
      es[11:0] = 12'h200;
      eo = es;
      put(8'h20, 8'h80, 8'h00, 1'b1, 1'b0);
   endtask
   task automatic t_sleep();
      es[47:36] = 12'hFFF;
      eo[47:36] = 12'hFFF;
      put(8'h17, 8'hC0, 8'h00, 1'b1, 1'b0);
   endtask
   task automatic t_bcast();
      eo = {4{12'h005}};
      put(8'h34, 8'h01, 8'h40, 1'b0, 1'b1);
      eo = es;
      put(8'h30, 8'h01, 8'h40, 1'b0, 1'b1);
      for (int i = 0; i < 4; i++) eo[i*12 +: 12] = {2'b10, es[i*12 +: 10]};
      put(8'h35, 8'h80, 8'h00, 1'b0, 1'b1);
   endtask
   task automatic t_refuse();
      put(8'h10, 8'hAA, 8'hAA, 1'b0, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Update pulses seen on the design's output
   always @(posedge clk_sys_in) begin
      if (upd === 1'b1)
         pulses++;
   end
   // Clock of 20 ns
   initial begin
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   // Main sequence
   initial begin
      repeat (3) @(posedge clk_sys_in);
      #1 reset_in = 1'b0;
      m.st(4);
      check("reset staging", 48'h0, stg);
      check("reset outputs", 48'h0, outc);
      t_temp();
      t_one();
      t_all();
      t_sleep();
      t_bcast();
      t_refuse();
      stop_test();
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      num_errors++;
      stop_test();
   end
endmodule
